//--- hdl/tcoc_top.v
`timescale 1ns/100ps
`default_nettype none
`include "tcoc_map.vh"
module tcoc_top (
	// Clock and reset
	input wire clk,
	input wire rstn,
	// AXI4-Lite write address
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Oscillator pin one, synchronised and counted on rising edges
	input wire osc_pin_one,
	// Port logic for the two oscillator pins
	input wire port_osc_one_out,
	input wire port_osc_one_dir,
	input wire port_osc_two_out,
	input wire port_osc_two_dir,
	output reg osc_one_port_detach,
	output reg osc_two_port_detach,
	output reg osc_pin_one_oe,
	output reg osc_pin_one_o,
	output reg osc_pin_two_oe,
	output reg osc_pin_two_o,
	// Compare pins with their port logic
	input wire port_a_out,
	input wire port_a_dir,
	input wire port_b_out,
	input wire port_b_dir,
	output reg compare_out_a_pin,
	output reg compare_out_a_oe,
	output reg compare_out_b_pin,
	output reg compare_out_b_oe,
	// Internal compare output states
	output reg compare_out_a,
	output reg compare_out_b
);
	localparam RESP_OKAY = 2'h0;
	localparam RESP_SLVERR = 2'h2;
	// One-hot waveform kinds
	localparam WV_NORMAL = 4'h1;
	localparam WV_CTC = 4'h2;
	localparam WV_FAST = 4'h4;
	localparam WV_PHASE = 4'h8;
	reg [7:0] timer_output_control_a;
	reg waveform_mode_top_bit;
	reg [2:0] clock_select_field;
	reg async_clock_select;
	reg [7:0] compare_value_a, compare_value_b;
	reg [7:0] count;
	reg count_down;
	reg osc_sync1, osc_sync2, osc_prev;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg aw_full, w_full, psc_clear;
	wire [1:0] out_a_mode, out_b_mode;
	wire [2:0] waveform_mode;
	wire [1:0] waveform_mode_low_bits;
	wire timer_source_clock, timer_tick;
	wire pwm_on, link_a;
	reg [3:0] wave;
	reg [7:0] top;
	reg [7:0] next_count;
	reg next_down, next_a, next_b;

	assign out_a_mode = timer_output_control_a[`TCOC_OUT_A_HI:`TCOC_OUT_A_LO];
	assign out_b_mode = timer_output_control_a[`TCOC_OUT_B_HI:`TCOC_OUT_B_LO];
	assign waveform_mode_low_bits = timer_output_control_a[1:0];
	assign waveform_mode = {waveform_mode_top_bit, waveform_mode_low_bits};
	// PWM mode 01 on channel A with the top bit clear stays disconnected
	assign pwm_on = (wave == WV_FAST) || (wave == WV_PHASE);
	assign link_a = (|out_a_mode) && !(pwm_on && out_a_mode == 2'h1 &&
		!waveform_mode_top_bit);
	// Source tick: every clock, or rising edge of the oscillator pin
	assign timer_source_clock = async_clock_select ?
		(osc_sync2 && !osc_prev) : 1'b1;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			osc_sync1 <= 1'b0;
			osc_sync2 <= 1'b0;
			osc_prev <= 1'b0;
		end else begin
			osc_sync1 <= osc_pin_one;
			osc_sync2 <= osc_sync1;
			osc_prev <= osc_sync2;
		end
	end
	tcoc_prescaler #(
		.WIDTH(`TCOC_PSC_WIDTH)
	) u_prescaler (
		.clk(clk),
		.rstn(rstn),
		.src_tick(timer_source_clock),
		.clear(psc_clear),
		.sel(clock_select_field),
		.tick(timer_tick)
	);
	// Waveform mode decode; reserved codes behave as normal
	always @* begin
		case (waveform_mode)
			3'h1: wave = WV_PHASE;
			3'h5: wave = WV_PHASE;
			3'h2: wave = WV_CTC;
			3'h3: wave = WV_FAST;
			3'h7: wave = WV_FAST;
			default: wave = WV_NORMAL;
		endcase
		if (waveform_mode == 3'h2 || waveform_mode_top_bit)
			top = compare_value_a;
		else
			top = `TCOC_MAX;
	end
	// Per-channel compare action
	function act;
		input [3:0] wv;
		input [1:0] mode;
		input cur;
		input match;
		input at_bottom;
		input at_top;
		input down;
		input is_top;
		input toggle_ok;
		begin
			act = cur;
			case (wv)
				WV_FAST: begin
					if (mode[1]) begin
						if (match && !is_top)
							act = mode[0];
						if (at_bottom)
							act = ~mode[0];
					end else if (mode[0] && toggle_ok && match)
						act = ~cur;
				end
				WV_PHASE: begin
					if (mode[1]) begin
						if (is_top) begin
							if (at_top)
								act = ~mode[0];
						end else if (match)
							act = down ? ~mode[0] : mode[0];
					end else if (mode[0] && toggle_ok && match)
						act = ~cur;
				end
				default: begin
					if (match) begin
						case (mode)
							2'h1: act = ~cur;
							2'h2: act = 1'b0;
							2'h3: act = 1'b1;
							default: act = cur;
						endcase
					end
				end
			endcase
		end
	endfunction
	// Counter stand-in that feeds compare events
	always @* begin
		next_count = count;
		next_down = count_down;
		if (wave == WV_PHASE) begin
			if (!count_down && count == top) begin
				next_down = 1'b1;
				next_count = count - 8'h01;
			end else if (count_down && count == `TCOC_BOTTOM) begin
				next_down = 1'b0;
				next_count = count + 8'h01;
			end else
				next_count = count_down ? count - 8'h01 : count + 8'h01;
		end else begin
			next_down = 1'b0;
			if (wave != WV_NORMAL && count == top)
				next_count = `TCOC_BOTTOM;
			else
				next_count = count + 8'h01;
		end
		next_a = act(wave, out_a_mode, compare_out_a,
			count == compare_value_a, next_count == `TCOC_BOTTOM &&
			wave == WV_FAST, count == top, count_down,
			compare_value_a == top, waveform_mode_top_bit);
		next_b = act(wave, out_b_mode, compare_out_b,
			count == compare_value_b, next_count == `TCOC_BOTTOM &&
			wave == WV_FAST, count == top, count_down,
			compare_value_b == top, 1'b0);
	end
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count <= 8'h00;
			count_down <= 1'b0;
			compare_out_a <= 1'b0;
			compare_out_b <= 1'b0;
		end else if (timer_tick) begin
			count <= next_count;
			count_down <= next_down;
			compare_out_a <= next_a;
			compare_out_b <= next_b;
		end
	end
	// Pin multiplexing
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			compare_out_a_pin <= 1'b0;
			compare_out_a_oe <= 1'b0;
			compare_out_b_pin <= 1'b0;
			compare_out_b_oe <= 1'b0;
			osc_one_port_detach <= 1'b0;
			osc_two_port_detach <= 1'b0;
			osc_pin_one_oe <= 1'b0;
			osc_pin_one_o <= 1'b0;
			osc_pin_two_oe <= 1'b0;
			osc_pin_two_o <= 1'b0;
		end else begin
			compare_out_a_pin <= link_a ? compare_out_a
				: port_a_out;
			compare_out_a_oe <= port_a_dir;
			compare_out_b_pin <= (|out_b_mode) ? compare_out_b
				: port_b_out;
			compare_out_b_oe <= port_b_dir;
			osc_one_port_detach <= async_clock_select;
			osc_two_port_detach <= async_clock_select;
			osc_pin_one_oe <= !async_clock_select && port_osc_one_dir;
			osc_pin_one_o <= port_osc_one_out;
			osc_pin_two_oe <= !async_clock_select && port_osc_two_dir;
			osc_pin_two_o <= port_osc_two_out;
		end
	end
	// AXI4-Lite slave
	assign s_axi_awready = !aw_full && !s_axi_bvalid;
	assign s_axi_wready = !w_full && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			psc_clear <= 1'b0;
			timer_output_control_a <= `TCOC_OUT_CTRL_RESET;
			{waveform_mode_top_bit, clock_select_field} <=
				`TCOC_WAVE_CLK_RESET;
			async_clock_select <= 1'b0;
			compare_value_a <= 8'h00;
			compare_value_b <= 8'h00;
		end else begin
			psc_clear <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (aw_full && w_full) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= RESP_OKAY;
				case (aw_addr)
					`TCOC_ADDR_OUT_CTRL:
						if (w_strb[0])
							timer_output_control_a <= w_data[7:0] &
								`TCOC_OUT_CTRL_MASK;
					`TCOC_ADDR_WAVE_CLK:
						if (w_strb[0]) begin
							waveform_mode_top_bit <=
								w_data[`TCOC_WAVE_TOP_BIT];
							clock_select_field <= w_data[2:0];
						end
					`TCOC_ADDR_COMPARE_A:
						if (w_strb[0])
							compare_value_a <= w_data[7:0];
					`TCOC_ADDR_COMPARE_B:
						if (w_strb[0])
							compare_value_b <= w_data[7:0];
					`TCOC_ADDR_GEN_CTRL:
						if (w_strb[0]) begin
							async_clock_select <=
								w_data[`TCOC_ASYNC_SEL_BIT];
							psc_clear <= w_data[`TCOC_PSC_RESET_BIT];
						end
					`TCOC_ADDR_STATUS: ;
					default: s_axi_bresp <= RESP_SLVERR;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				s_axi_rdata <= 32'h00000000;
				case (s_axi_araddr)
					`TCOC_ADDR_OUT_CTRL:
						s_axi_rdata[7:0] <= timer_output_control_a;
					`TCOC_ADDR_WAVE_CLK:
						s_axi_rdata[3:0] <= {waveform_mode_top_bit,
							clock_select_field};
					`TCOC_ADDR_COMPARE_A:
						s_axi_rdata[7:0] <= compare_value_a;
					`TCOC_ADDR_COMPARE_B:
						s_axi_rdata[7:0] <= compare_value_b;
					`TCOC_ADDR_GEN_CTRL:
						s_axi_rdata[0] <= async_clock_select;
					`TCOC_ADDR_STATUS:
						s_axi_rdata[10:0] <= {compare_out_b,
							compare_out_a, count_down, count};
					default: s_axi_rresp <= RESP_SLVERR;
				endcase
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- hdl/tcoc_map.vh
`ifndef TCOC_MAP_VH
`define TCOC_MAP_VH
// Register byte addresses
`define TCOC_ADDR_OUT_CTRL 8'hB0
`define TCOC_ADDR_WAVE_CLK 8'hB1
`define TCOC_ADDR_COMPARE_A 8'hB3
`define TCOC_ADDR_COMPARE_B 8'hB4
`define TCOC_ADDR_GEN_CTRL 8'hB8
`define TCOC_ADDR_STATUS 8'hBC
// Field positions
`define TCOC_OUT_A_HI 7
`define TCOC_OUT_A_LO 6
`define TCOC_OUT_B_HI 5
`define TCOC_OUT_B_LO 4
`define TCOC_WAVE_TOP_BIT 3
`define TCOC_ASYNC_SEL_BIT 0
`define TCOC_PSC_RESET_BIT 1
// Reset values, masks and counter limits
`define TCOC_OUT_CTRL_RESET 8'h00
`define TCOC_OUT_CTRL_MASK 8'hF3
`define TCOC_WAVE_CLK_RESET 4'h0
`define TCOC_MAX 8'hFF
`define TCOC_BOTTOM 8'h00
// Prescaler taps
`define TCOC_PSC_WIDTH 10
`endif

//--- hdl/tcoc_prescaler.v
`timescale 1ns/100ps
`default_nettype none
// Source clock prescaler, produces one-cycle count enables
module tcoc_prescaler #(
	parameter WIDTH = 10
) (
	// Clock and reset
	input wire clk,
	input wire rstn,
	// Control
	input wire src_tick,
	input wire clear,
	input wire [2:0] sel,
	// Output
	output reg tick
);
	reg [WIDTH-1:0] count;
	reg [WIDTH-1:0] next_count;
	reg hit;

	always @* begin
		next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
		case (sel)
			3'h0: hit = 1'b0;
			3'h1: hit = src_tick;
			3'h2: hit = src_tick && (next_count[2:0] == 3'h0);
			3'h3: hit = src_tick && (next_count[4:0] == 5'h00);
			3'h4: hit = src_tick && (next_count[5:0] == 6'h00);
			3'h5: hit = src_tick && (next_count[6:0] == 7'h00);
			3'h6: hit = src_tick && (next_count[7:0] == 8'h00);
			default: hit = src_tick && (next_count[9:0] == 10'h000);
		endcase
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count <= {WIDTH{1'b0}};
			tick <= 1'b0;
		end else if (clear) begin
			count <= {WIDTH{1'b0}};
			tick <= 1'b0;
		end else begin
			if (src_tick)
				count <= next_count;
			tick <= hit;
		end
	end
endmodule
`default_nettype wire

//--- verification/tcoc_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module tcoc_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pins
	input wire logic port_a_dir,
	input wire logic port_b_dir,
	input wire logic compare_out_a_oe,
	input wire logic compare_out_b_oe,
	input wire logic osc_one_port_detach,
	input wire logic osc_two_port_detach,
	input wire logic osc_pin_one_oe,
	input wire logic osc_pin_two_oe
);
	logic [7:0] rd_addr;
	logic mapped;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// Address of the read under way
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rd_addr <= 8'h00;
		else if (s_axi_arvalid && s_axi_arready)
			rd_addr <= s_axi_araddr;
	end
	assign mapped = rd_addr inside {8'hB0, 8'hB1, 8'hB3, 8'hB4, 8'hB8, 8'hBC};
	AST_AR_ANSWER: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("no read answer");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
	AST_UNMAPPED: assert property (s_axi_rvalid && !mapped
		|-> s_axi_rresp == 2'h2) else $error("unmapped read ok");
	AST_CTRL_RSV: assert property (s_axi_rvalid && rd_addr == 8'hB0 |->
		(s_axi_rdata & 32'hFFFFFF0C) == 32'h0) else $error("reserved set");
	AST_OE_A: assert property ($past(rstn) |->
		compare_out_a_oe == $past(port_a_dir)) else $error("oe a wrong");
	AST_OE_B: assert property ($past(rstn) |->
		compare_out_b_oe == $past(port_b_dir)) else $error("oe b wrong");
	AST_DETACH_PAIR: assert property (
		osc_one_port_detach == osc_two_port_detach) else $error("detach split");
	AST_DETACH_OE: assert property ($past(osc_one_port_detach) &&
		osc_one_port_detach |-> !osc_pin_one_oe && !osc_pin_two_oe)
		else $error("osc pin driven");
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	cover property (osc_one_port_detach);
	cover property (compare_out_a_oe && compare_out_b_oe);
endmodule
bind tcoc_top tcoc_asserts u_chk (.clk, .rstn, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .port_a_dir, .port_b_dir,
	.compare_out_a_oe, .compare_out_b_oe, .osc_one_port_detach,
	.osc_two_port_detach, .osc_pin_one_oe, .osc_pin_two_oe);
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CK(n, e, g) begin \
	n_compared++; \
	if ((g) !== (e)) begin \
		n_mismatch++; \
		$display("[FAIL] %s exp %0h got %0h", n, e, g); \
	end \
end
module tb_top;
	logic clk = 1'h0, rstn = 1'h0, osc_run = 1'h0, osc_pin_one = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, oc = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic port_osc_one_out = 1'h0, port_osc_two_out = 1'h0;
	logic port_osc_one_dir = 1'h1, port_osc_two_dir = 1'h1;
	logic port_a_out = 1'h0, port_a_dir = 1'h0;
	logic port_b_out = 1'h0, port_b_dir = 1'h0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, osc_one_port_detach, osc_two_port_detach;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire osc_pin_one_oe, osc_pin_one_o, osc_pin_two_oe, osc_pin_two_o;
	wire compare_out_a_pin, compare_out_a_oe, compare_out_a;
	wire compare_out_b_pin, compare_out_b_oe, compare_out_b;
	int n_mismatch = 0, n_compared = 0, ha, hb, ta, tb, m, n;
	int div_tgl[8] = '{0, 2048, 256, 64, 32, 16, 8, 2};
	logic [7:0] pw_cmp[4] = '{8'h40, 8'hFF, 8'h40, 8'hFF};
	logic [7:0] pw_ctl[4] = '{8'hB3, 8'hB3, 8'hB1, 8'hB1};
	int pw_per[4] = '{256, 256, 510, 510};
	int pw_ea[4] = '{65, 256, 128, 510};
	int pw_eb[4] = '{191, 0, 382, 0};
	logic [31:0] d;
	logic [1:0] r;
	tcoc_top u_dut (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_pin_one,
		.port_osc_one_out, .port_osc_one_dir, .port_osc_two_out,
		.port_osc_two_dir, .osc_one_port_detach, .osc_two_port_detach,
		.osc_pin_one_oe, .osc_pin_one_o, .osc_pin_two_oe, .osc_pin_two_o,
		.port_a_out, .port_a_dir, .port_b_out, .port_b_dir,
		.compare_out_a_pin, .compare_out_a_oe, .compare_out_b_pin,
		.compare_out_b_oe, .compare_out_a, .compare_out_b);
	initial begin
		forever #50 clk = ~clk;
	end
	// Slow crystal stand-in, eight clocks a period, still when stopped
	always @(posedge clk) begin
		oc <= oc + 8'h01;
		if (osc_run)
			osc_pin_one <= oc[2];
	end
	// One register access, write when w is set
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [7:0] v);
		logic ga, gw, gr, gv;
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= {24'h000000, v};
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		repeat (99) begin
			@(negedge clk);
			ga = s_axi_awvalid && s_axi_awready;
			gw = s_axi_wvalid && s_axi_wready;
			gr = s_axi_arvalid && s_axi_arready;
			gv = w ? s_axi_bvalid : s_axi_rvalid;
			r = w ? s_axi_bresp : s_axi_rresp;
			d = s_axi_rdata;
			@(posedge clk);
			if (ga)
				s_axi_awvalid <= 1'h0;
			if (gw)
				s_axi_wvalid <= 1'h0;
			if (gr)
				s_axi_arvalid <= 1'h0;
			if (gv) begin
				s_axi_bready <= 1'h0;
				s_axi_rready <= 1'h0;
				`CK("resp", {a == 8'hB2, 1'h0}, r)
				@(posedge clk);
				return;
			end
		end
		$display("[FAIL] bus_wait exp answer got none");
		n_mismatch++;
		give_verdict;
	endtask
	// High cycles and toggles of both compare outputs over c cycles
	task automatic win(input int c);
		logic pa, pb;
		ha = 0;
		hb = 0;
		ta = 0;
		tb = 0;
		@(negedge clk);
		pa = compare_out_a;
		pb = compare_out_b;
		repeat (c) begin
			@(negedge clk);
			ha += compare_out_a;
			hb += compare_out_b;
			ta += compare_out_a ^ pa;
			tb += compare_out_b ^ pb;
			pa = compare_out_a;
			pb = compare_out_b;
		end
		@(posedge clk);
	endtask
	task give_verdict;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'h1;
		@(posedge clk);
		acc(0, 8'hB0, 8'h00);
		`CK("ctl_rst", 32'h0, d)
		acc(1, 8'hB0, 8'hFF);
		acc(0, 8'hB0, 8'h00);
		`CK("ctl_rw", 32'hF3, d)
		acc(1, 8'hB2, 8'hFF);
		acc(0, 8'hB2, 8'h00);
		$display("register test done");
		acc(1, 8'hB1, 8'h01);
		acc(1, 8'hB3, 8'h10);
		acc(1, 8'hB4, 8'h20);
		for (m = 3; m > 0; m--) begin
			acc(1, 8'hB0, {m[1:0], m[1:0], 4'h0});
			win(600);
			win(512);
			`CK("lvl_a", m == 1 ? 2 : (m - 2) * 512, m == 1 ? ta : ha)
			`CK("lvl_b", m == 1 ? 2 : (m - 2) * 512, m == 1 ? tb : hb)
		end
		port_a_dir <= 1'h1;
		port_b_dir <= 1'h1;
		port_a_out <= 1'h1;
		port_b_out <= 1'h1;
		acc(1, 8'hB0, 8'hC0);
		win(600);
		`CK("pin_b", 1'h1, compare_out_b_pin)
		acc(1, 8'hB0, 8'h00);
		port_a_out <= 1'h0;
		port_b_out <= 1'h0;
		win(600);
		`CK("pin_a", 1'h0, compare_out_a_pin)
		`CK("keep_a", 1'h1, compare_out_a)
		`CK("pin_b", 1'h0, compare_out_b_pin)
		$display("output mode test done");
		for (m = 0; m < 4; m++) begin
			acc(1, 8'hB3, pw_cmp[m]);
			acc(1, 8'hB4, pw_cmp[m]);
			acc(1, 8'hB0, pw_ctl[m]);
			win(1100);
			win(pw_per[m]);
			`CK("pwm_a", pw_ea[m], ha)
			`CK("pwm_b", pw_eb[m], hb)
		end
		// Channel A state is high here, its port value low
		acc(1, 8'hB0, 8'h41);
		win(600);
		`CK("dis_a", 1'h0, compare_out_a_pin)
		`CK("dis_a_keep", 1'h1, compare_out_a)
		acc(1, 8'hB3, 8'h1F);
		acc(1, 8'hB1, 8'h09);
		acc(1, 8'hB0, 8'h43);
		win(600);
		win(256);
		`CK("tgl_top", 8, ta)
		$display("pwm test done");
		acc(1, 8'hB3, 8'h00);
		acc(1, 8'hB0, 8'h42);
		for (m = 0; m < 8; m++) begin
			acc(1, 8'hB1, m[7:0]);
			win(1100);
			win(2048);
			`CK("div", div_tgl[m], ta)
		end
		// Clearing every 500 cycles must keep the divide-by-1024 silent
		acc(1, 8'hB8, 8'h02);
		n = 0;
		repeat (6) begin
			win(500);
			n += ta;
			acc(1, 8'hB8, 8'h02);
		end
		`CK("psc_clr", 0, n)
		$display("prescaler test done");
		acc(1, 8'hB1, 8'h01);
		osc_run <= 1'h1;
		acc(1, 8'hB8, 8'h01);
		win(1100);
		`CK("detach", 1'h1, osc_one_port_detach)
		`CK("osc_oe", 1'h0, osc_pin_one_oe)
		win(2048);
		`CK("async", 256, ta)
		osc_run <= 1'h0;
		win(100);
		win(2048);
		`CK("async_stop", 0, ta)
		acc(1, 8'hB8, 8'h00);
		`CK("attach", 1'h0, osc_two_port_detach)
		`CK("osc_oe_back", 1'h1, osc_pin_one_oe)
		$display("clock source test done");
		give_verdict;
	end
endmodule
`default_nettype wire
